// file: hdl/trf_pkg.sv
// Package for the touch result filter: offsets, field positions,
// reset values, timing counts and the sample carrier type.
// Assumes a 50 MHz system clock and 16-bit registers on a plain port.
package trf_pkg;

	// ==================================================================
	// Register offsets
	localparam logic [3:0] OFF_FIRST_CONTROL = 4'h1;
	localparam logic [3:0] OFF_SECOND_CONTROL = 4'h2;
	localparam logic [3:0] OFF_THIRD_CONTROL = 4'h3;
	localparam logic [3:0] OFF_MON_HIGH_LIMIT = 4'h4;
	localparam logic [3:0] OFF_MON_LOW_LIMIT = 4'h5;
	localparam logic [3:0] OFF_MON_RESULT = 4'hc;

	// ==================================================================
	// Reset values
	localparam logic [15:0] RST_FIRST_CONTROL = 16'h0000;
	localparam logic [15:0] RST_SECOND_CONTROL = 16'h4040;
	localparam logic [15:0] RST_ZERO = 16'h0000;

	// ==================================================================
	// Field positions in the first and second control registers
	localparam int CHAN_MSB = 14;
	localparam int CHAN_LSB = 12;
	localparam int MED_MSB = 6;
	localparam int MED_LSB = 5;
	localparam int AVG_MSB = 8;
	localparam int AVG_LSB = 7;
	localparam int PORT_EN_BIT = 13;
	localparam int PORT_DATA_BIT = 12;
	localparam int PORT_DIR_BIT = 11;
	localparam int PORT_POL_BIT = 10;

	// Third control register layout.
	localparam int HI_STAT_BIT = 0;
	localparam int LO_STAT_BIT = 1;
	localparam int HI_EN_BIT = 2;
	localparam int LO_EN_BIT = 3;
	localparam int ALERT_SEL_BIT = 4;

	// Channel address codes.
	localparam logic [2:0] CHAN_BATTERY = 3'h2;
	localparam logic [2:0] CHAN_SPARE = 3'h3;

	// ==================================================================
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int RANK_SORT_TIME_NS = 2000;
	localparam int SORT_CYCLES_RAW =
		(RANK_SORT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SORT_CYCLES = (SORT_CYCLES_RAW < 1) ? 1 : SORT_CYCLES_RAW;

	// ==================================================================
	// Carrier for one converted sample from the sequencer.
	typedef struct packed {
		logic valid;
		logic [11:0] data;
	} trf_sample_t;

endpackage : trf_pkg

// file: hdl/trf_top.sv
// Median/averaging filter, spare- and battery-channel limit check and port pin logic.
// Assumes the conversion sequencer runs on clk_i and delivers one-cycle
// sample strobes; the port pin comes from outside and is synchronised.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps

module trf_top #(
	parameter int DEPTH = 16,
	parameter int SAMPLE_W = 12
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire trf_pkg::trf_sample_t sample_i,
	input wire logic acquire_i,
	output logic sort_busy_o,
	output logic [SAMPLE_W-1:0] result_o,
	output logic [2:0] result_chan_o,
	output logic result_valid_o,
	output logic bat_div_en_o,
	output logic shared_interrupt_pin_n_o,
	input wire logic port_pin_i,
	output logic port_pin_o,
	output logic port_pin_oe_o
);

	// ==================================================================
	// Decoding helpers

	// Number of measurements taken for one result.
	function automatic logic [4:0] win_count(input logic [1:0] med,
		input logic [1:0] avg);
		logic [4:0] r;
		r = 5'h01;
		unique case (med)
			2'h1: r = 5'h04;
			2'h2: r = 5'h08;
			2'h3: r = 5'h10;
			2'h0: r = (avg == 2'h0) ? 5'h01 : avg_count(med, avg);
		endcase
		return r;
	endfunction : win_count

	// Number of values averaged; one when both fields are zero.
	function automatic logic [4:0] avg_count(input logic [1:0] med,
		input logic [1:0] avg);
		logic [4:0] r;
		r = 5'h02;
		unique case (avg)
			2'h0: r = (med == 2'h0) ? 5'h01 : 5'h02;
			2'h1: r = 5'h04;
			2'h2: r = 5'h08;
			2'h3: r = 5'h10;
		endcase
		return r;
	endfunction : avg_count

	// Shift that divides by the averaging count.
	function automatic logic [2:0] avg_shift(input logic [4:0] cnt);
		logic [2:0] r;
		r = 3'h0;
		for (int b = 0; b < 5; b++) begin
			if (cnt[b]) begin
				r = 3'(b);
			end
		end
		return r;
	endfunction : avg_shift

	// ==================================================================
	// Registers
	logic [15:0] first_control_reg;
	logic [15:0] second_control_reg;
	logic [15:0] mon_high_limit_reg;
	logic [15:0] mon_low_limit_reg;
	logic [SAMPLE_W-1:0] mon_result_reg;
	logic hi_stat_reg;
	logic lo_stat_reg;
	logic hi_en_reg;
	logic lo_en_reg;
	logic alert_sel_reg;
	logic pin_sync1_reg;
	logic pin_sync2_reg;

	logic [2:0] chan;
	logic [1:0] med_field;
	logic [1:0] avg_field;
	logic [4:0] m_cnt;
	logic [4:0] a_cnt;
	logic port_en;
	logic port_dir;
	logic port_pol;
	logic port_input_mode;

	assign chan = first_control_reg[trf_pkg::CHAN_MSB:trf_pkg::CHAN_LSB];
	assign med_field = second_control_reg[trf_pkg::MED_MSB:trf_pkg::MED_LSB];
	assign avg_field = second_control_reg[trf_pkg::AVG_MSB:trf_pkg::AVG_LSB];
	assign m_cnt = win_count(med_field, avg_field);
	assign a_cnt = avg_count(med_field, avg_field);
	assign port_en = second_control_reg[trf_pkg::PORT_EN_BIT];
	assign port_dir = second_control_reg[trf_pkg::PORT_DIR_BIT];
	assign port_pol = second_control_reg[trf_pkg::PORT_POL_BIT];
	assign port_input_mode = port_en & port_dir;

	logic wr_first;
	logic wr_second;
	logic wr_third;
	assign wr_first = wr_i & (addr_i == trf_pkg::OFF_FIRST_CONTROL);
	assign wr_second = wr_i & (addr_i == trf_pkg::OFF_SECOND_CONTROL);
	assign wr_third = wr_i & (addr_i == trf_pkg::OFF_THIRD_CONTROL);

	// ==================================================================
	// Filter state
	typedef enum logic [1:0] {
		ST_COLLECT,
		ST_SORT,
		ST_SUM,
		ST_WRITE
	} trf_state_t;

	trf_state_t state_reg;
	logic [SAMPLE_W-1:0] rank_reg [DEPTH];
	logic [SAMPLE_W-1:0] rank_next [DEPTH];
	logic [4:0] fill_reg;
	logic [6:0] sort_cnt_reg;
	logic [3:0] sum_idx_reg;
	logic [4:0] sum_left_reg;
	logic [SAMPLE_W+3:0] sum_reg;
	logic [DEPTH-1:0] le_vec;
	logic [4:0] ins_pos;
	logic take_sample;
	logic [SAMPLE_W-1:0] avg_value;
	logic limit_hi;
	logic limit_lo;
	logic mon_chan;

	assign take_sample = sample_i.valid & (state_reg == ST_COLLECT);
	assign mon_chan = (chan == trf_pkg::CHAN_SPARE) |
		(chan == trf_pkg::CHAN_BATTERY);
	assign avg_value = SAMPLE_W'(sum_reg >> avg_shift(a_cnt));

	// Entries not above the new sample; the sample goes behind them.
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_rank_cmp
			assign le_vec[gi] = (5'(gi) < fill_reg) &&
				(rank_reg[gi] <= sample_i.data);
		end
	endgenerate

	// Insertion position is the count of entries at or below the sample.
	always_comb begin
		ins_pos = 5'h00;
		for (int i = 0; i < DEPTH; i++) begin
			ins_pos = ins_pos + {4'h0, le_vec[i]};
		end
	end

	// Ranked array with the new sample slotted in, larger entries moved up.
	always_comb begin
		rank_next[0] = (ins_pos == 5'h00) ? sample_i.data : rank_reg[0];
		for (int i = 1; i < DEPTH; i++) begin
			if (5'(i) < ins_pos) begin
				rank_next[i] = rank_reg[i];
			end else if (5'(i) == ins_pos) begin
				rank_next[i] = sample_i.data;
			end else begin
				rank_next[i] = rank_reg[i-1];
			end
		end
	end

	// Ranked array storage; only a taken sample changes it.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				rank_reg[i] <= '0;
			end
		end else if (take_sample) begin
			for (int i = 0; i < DEPTH; i++) begin
				rank_reg[i] <= rank_next[i];
			end
		end
	end

	// Window sequencing: collect, hold for the sort time, then sum.
	// A write to the first control register restarts the window, so a
	// channel change never mixes samples from two inputs.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_COLLECT;
			fill_reg <= 5'h00;
			sort_cnt_reg <= 7'h00;
			sum_idx_reg <= 4'h0;
			sum_left_reg <= 5'h00;
			sum_reg <= '0;
		end else if (wr_first) begin
			state_reg <= ST_COLLECT;
			fill_reg <= 5'h00;
		end else begin
			unique case (state_reg)
				ST_COLLECT: begin
					if (take_sample) begin
						fill_reg <= fill_reg + 5'h01;
						sort_cnt_reg <= 7'(trf_pkg::SORT_CYCLES);
						// Equal counts skip the sort time entirely.
						if (m_cnt != a_cnt) begin
							state_reg <= ST_SORT;
						end else if (fill_reg + 5'h01 >= m_cnt) begin
							state_reg <= ST_SUM;
						end
						sum_idx_reg <= 4'((m_cnt - a_cnt) >> 1);
						sum_left_reg <= a_cnt;
						sum_reg <= '0;
					end
				end
				ST_SORT: begin
					sort_cnt_reg <= sort_cnt_reg - 7'h01;
					if (sort_cnt_reg == 7'h01) begin
						state_reg <= (fill_reg >= m_cnt) ? ST_SUM :
							ST_COLLECT;
					end
				end
				ST_SUM: begin
					sum_reg <= sum_reg + {4'h0, rank_reg[sum_idx_reg]};
					sum_idx_reg <= sum_idx_reg + 4'h1;
					sum_left_reg <= sum_left_reg - 5'h01;
					if (sum_left_reg == 5'h01) begin
						state_reg <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					state_reg <= ST_COLLECT;
					fill_reg <= 5'h00;
				end
			endcase
		end
	end

	// Finished result toward the rest of the chip; only the average leaves.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			result_o <= '0;
			result_chan_o <= 3'h0;
			result_valid_o <= 1'b0;
			sort_busy_o <= 1'b0;
		end else begin
			result_valid_o <= (state_reg == ST_WRITE);
			sort_busy_o <= (state_reg == ST_SORT);
			if (state_reg == ST_WRITE) begin
				result_o <= avg_value;
				result_chan_o <= chan;
			end
		end
	end

	// Monitor result register is loaded once per finished window on the spare or battery channel.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mon_result_reg <= '0;
		end else if ((state_reg == ST_WRITE) && mon_chan) begin
			mon_result_reg <= avg_value;
		end
	end

	// ==================================================================
	// Limit check against the shared limits, on the fresh average.
	assign limit_hi = (state_reg == ST_WRITE) && mon_chan &&
		(avg_value > mon_high_limit_reg[SAMPLE_W-1:0]);
	assign limit_lo = (state_reg == ST_WRITE) && mon_chan &&
		(avg_value < mon_low_limit_reg[SAMPLE_W-1:0]);

	// Status bits are write-one-to-clear; a new violation wins over a clear.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hi_stat_reg <= 1'b0;
			lo_stat_reg <= 1'b0;
		end else begin
			hi_stat_reg <= limit_hi | (hi_stat_reg &
				~(wr_third & wdata_i[trf_pkg::HI_STAT_BIT]));
			lo_stat_reg <= limit_lo | (lo_stat_reg &
				~(wr_third & wdata_i[trf_pkg::LO_STAT_BIT]));
		end
	end

	// Alert enables and function select.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hi_en_reg <= 1'b0;
			lo_en_reg <= 1'b0;
			alert_sel_reg <= 1'b0;
		end else if (wr_third) begin
			hi_en_reg <= wdata_i[trf_pkg::HI_EN_BIT];
			lo_en_reg <= wdata_i[trf_pkg::LO_EN_BIT];
			alert_sel_reg <= wdata_i[trf_pkg::ALERT_SEL_BIT];
		end
	end

	// Interrupt pin is active low and pulled while alert select is set and an enabled status bit stands.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shared_interrupt_pin_n_o <= 1'b1;
		end else begin
			shared_interrupt_pin_n_o <= ~(alert_sel_reg &
				((hi_stat_reg & hi_en_reg) |
				(lo_stat_reg & lo_en_reg)));
		end
	end

	// Divider draws current, so it follows the acquisition window only, on the battery channel with the port disabled.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bat_div_en_o <= 1'b0;
		end else begin
			bat_div_en_o <= acquire_i & ~port_en &
				(chan == trf_pkg::CHAN_BATTERY);
		end
	end

	// ==================================================================
	// Port pin

	// Two-stage synchroniser for the asynchronous pin level.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_sync1_reg <= 1'b0;
			pin_sync2_reg <= 1'b0;
		end else begin
			pin_sync1_reg <= port_pin_i;
			pin_sync2_reg <= pin_sync1_reg;
		end
	end

	// Pin drive: enabled only as a port in output direction.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port_pin_o <= 1'b0;
			port_pin_oe_o <= 1'b0;
		end else begin
			port_pin_oe_o <= port_en & ~port_dir;
			port_pin_o <= port_pol ?
				second_control_reg[trf_pkg::PORT_DATA_BIT] :
				~second_control_reg[trf_pkg::PORT_DATA_BIT];
		end
	end

	// ==================================================================
	// Control registers written by the host

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			first_control_reg <= trf_pkg::RST_FIRST_CONTROL;
		end else if (wr_first) begin
			first_control_reg <= wdata_i;
		end
	end

	// In input mode the data bit follows the pin and host writes to it
	// are dropped; the other bits still take the written value.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			second_control_reg <= trf_pkg::RST_SECOND_CONTROL;
		end else begin
			if (wr_second) begin
				second_control_reg <= wdata_i;
			end
			if (port_input_mode) begin
				second_control_reg[trf_pkg::PORT_DATA_BIT] <=
					port_pol ? pin_sync2_reg : ~pin_sync2_reg;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mon_high_limit_reg <= trf_pkg::RST_ZERO;
			mon_low_limit_reg <= trf_pkg::RST_ZERO;
		end else if (wr_i) begin
			if (addr_i == trf_pkg::OFF_MON_HIGH_LIMIT) begin
				mon_high_limit_reg <= wdata_i;
			end
			if (addr_i == trf_pkg::OFF_MON_LOW_LIMIT) begin
				mon_low_limit_reg <= wdata_i;
			end
		end
	end

	// Read data one cycle after the strobe; unmapped offsets read zero.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= trf_pkg::RST_ZERO;
		end else if (rd_i) begin
			unique case (addr_i)
				trf_pkg::OFF_FIRST_CONTROL: rdata_o <= first_control_reg;
				trf_pkg::OFF_SECOND_CONTROL: rdata_o <= second_control_reg;
				trf_pkg::OFF_THIRD_CONTROL: rdata_o <= {11'h000,
					alert_sel_reg, lo_en_reg, hi_en_reg,
					lo_stat_reg, hi_stat_reg};
				trf_pkg::OFF_MON_HIGH_LIMIT: rdata_o <= mon_high_limit_reg;
				trf_pkg::OFF_MON_LOW_LIMIT: rdata_o <= mon_low_limit_reg;
				trf_pkg::OFF_MON_RESULT: rdata_o <= {4'h0, mon_result_reg};
				default: rdata_o <= trf_pkg::RST_ZERO;
			endcase
		end else begin
			rdata_o <= trf_pkg::RST_ZERO;
		end
	end

endmodule : trf_top

// file: sim/trf_top_props.sv
// Port checker for trf_top: filter output, limit alarm and pin logic.
// Assumes whole-word host writes. The pin-driven data bit is not
// shadowed, so output checks expect the host to have set that bit last.
`timescale 1ns/10ps

module trf_top_props #(
	parameter int DEPTH = 16,
	parameter int SAMPLE_W = 12
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire trf_pkg::trf_sample_t sample_i,
	input wire logic acquire_i,
	input wire logic sort_busy_o,
	input wire logic [SAMPLE_W-1:0] result_o,
	input wire logic [2:0] result_chan_o,
	input wire logic result_valid_o,
	input wire logic bat_div_en_o,
	input wire logic shared_interrupt_pin_n_o,
	input wire logic port_pin_i,
	input wire logic port_pin_o,
	input wire logic port_pin_oe_o
);
	// ==========
	// Shadows
	// Copies of host writes, so relations can be tied to the settings.
	logic [15:0] c1_reg, c2_reg, c3_reg, hi_reg, lo_reg;
	logic [7:0] busy_reg;
	logic mon_w;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			c1_reg <= 16'h0000;
			c2_reg <= trf_pkg::RST_SECOND_CONTROL;
			c3_reg <= 16'h0000;
			hi_reg <= 16'h0000;
			lo_reg <= 16'h0000;
		end else if (wr_i) begin
			case (addr_i)
				trf_pkg::OFF_FIRST_CONTROL: c1_reg <= wdata_i;
				trf_pkg::OFF_SECOND_CONTROL: c2_reg <= wdata_i;
				trf_pkg::OFF_THIRD_CONTROL: c3_reg <= wdata_i;
				trf_pkg::OFF_MON_HIGH_LIMIT: hi_reg <= wdata_i;
				trf_pkg::OFF_MON_LOW_LIMIT: lo_reg <= wdata_i;
				default: ;
			endcase
		end
	end

	// Length of the current sort hold, in cycles.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_reg <= 8'h00;
		end else begin
			busy_reg <= sort_busy_o ? busy_reg + 8'h01 : 8'h00;
		end
	end

	assign mon_w = (result_chan_o == trf_pkg::CHAN_SPARE) ||
		(result_chan_o == trf_pkg::CHAN_BATTERY);

	// ==========
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_take;
		sample_i.valid && c2_reg[8:5] == 4'h0;
	endsequence
	sequence s_out;
		##3 result_valid_o && result_o == $past(sample_i.data, 3);
	endsequence
	sequence s_hi;
		result_valid_o && mon_w && result_o > hi_reg[11:0] &&
			c3_reg[2] && c3_reg[4];
	endsequence
	sequence s_lo;
		result_valid_o && mon_w && result_o < lo_reg[11:0] &&
			c3_reg[3] && c3_reg[4];
	endsequence

	property p_single;
		s_take |-> s_out;
	endproperty
	property p_pulse;
		result_valid_o |=> !result_valid_o;
	endproperty
	property p_hold;
		!result_valid_o |-> $stable(result_o);
	endproperty
	property p_sort;
		$fell(sort_busy_o) |-> busy_reg == 8'(trf_pkg::SORT_CYCLES);
	endproperty
	property p_bat;
		bat_div_en_o == ($past(acquire_i) && !$past(c2_reg[13]) &&
			$past(c1_reg[14:12]) == trf_pkg::CHAN_BATTERY);
	endproperty
	property p_oe;
		port_pin_oe_o == ($past(c2_reg[13]) && !$past(c2_reg[11]));
	endproperty
	property p_pin;
		port_pin_oe_o |-> port_pin_o == ($past(c2_reg[12]) ~^ $past(c2_reg[10]));
	endproperty
	property p_hi;
		s_hi |=> !shared_interrupt_pin_n_o;
	endproperty
	property p_lo;
		s_lo |=> !shared_interrupt_pin_n_o;
	endproperty
	property p_mask;
		$fell(shared_interrupt_pin_n_o) |-> c3_reg[4] && (c3_reg[2] || c3_reg[3]);
	endproperty
	property p_rd;
		$past(rd_i) && $past(addr_i) == trf_pkg::OFF_MON_RESULT |->
			rdata_o[15:12] == 4'h0;
	endproperty

	a_single: assert property (p_single) else $error("single result wrong");
	a_pulse: assert property (p_pulse) else $error("result pulse too long");
	a_hold: assert property (p_hold) else $error("result moved alone");
	a_sort: assert property (p_sort) else $error("sort hold length");
	a_bat: assert property (p_bat) else $error("divider enable");
	a_oe: assert property (p_oe) else $error("pin enable");
	a_pin: assert property (p_pin) else $error("pin level");
	a_hi: assert property (p_hi) else $error("high alarm missing");
	a_lo: assert property (p_lo) else $error("low alarm missing");
	a_mask: assert property (p_mask) else $error("alarm not masked");
	a_rd: assert property (p_rd) else $error("result upper bits");

endmodule : trf_top_props

bind trf_top trf_top_props #(.DEPTH(DEPTH), .SAMPLE_W(SAMPLE_W))
	u_trf_top_props (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .sample_i, .acquire_i, .sort_busy_o, .result_o,
	.result_chan_o, .result_valid_o, .bat_div_en_o,
	.shared_interrupt_pin_n_o, .port_pin_i, .port_pin_o, .port_pin_oe_o);

// file: sim/trf_host_model.sv
// Host model: drives the plain register port of trf_top.
// Assumes a free-running clk_i; the testbench calls its tasks.
`timescale 1ns/10ps

module trf_host_model (
	input wire logic clk_i,
	output logic [3:0] addr_o,
	output logic [15:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [15:0] rdata_i
);
	// ==========
	// Bus cycles
	// Idle lines show the inverse of the last value, so a device that
	// samples them outside a strobe gets garbage, not a lucky match.
	initial begin
		addr_o = 4'h0;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		d = rdata_i;
	endtask : rd_reg

endmodule : trf_host_model

// file: sim/tb_trf_top.sv
// Testbench for trf_top: filter settings table, then masking and pin.
// Assumes trf_host_model on the register port and the bound checker.
`timescale 1ns/10ps

module tb_trf_top;
	typedef struct {
		logic [1:0] med;
		logic [1:0] avg;
		logic [2:0] chan;
		logic [11:0] base;
		logic [11:0] res;
		logic [1:0] stat;
	} trf_row_t;

	// Limits are 0x0aa high and 0x078 low; stat is {low, high}.
	// Every row keeps the median count at or above the average.
	trf_row_t rows [11] = '{
		'{2'h0, 2'h0, 3'h3, 12'h064, 12'h064, 2'h2},
		'{2'h0, 2'h0, 3'h2, 12'h0aa, 12'h0aa, 2'h0},
		'{2'h0, 2'h0, 3'h3, 12'h0ab, 12'h0ab, 2'h1},
		'{2'h0, 2'h0, 3'h2, 12'h078, 12'h078, 2'h0},
		'{2'h1, 2'h0, 3'h3, 12'h064, 12'h073, 2'h2},
		'{2'h1, 2'h1, 3'h2, 12'h064, 12'h073, 2'h2},
		'{2'h2, 2'h0, 3'h3, 12'h064, 12'h087, 2'h0},
		'{2'h2, 2'h1, 3'h3, 12'h064, 12'h087, 2'h0},
		'{2'h3, 2'h2, 3'h2, 12'h064, 12'h0af, 2'h1},
		'{2'h3, 2'h3, 3'h3, 12'h064, 12'h0af, 2'h1},
		'{2'h0, 2'h1, 3'h3, 12'h064, 12'h073, 2'h2}
	};
	logic [3:0] zoff [6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'hc, 4'h0};
	logic [15:0] pcfg [4] = '{16'h3400, 16'h3000, 16'h2000, 16'h0400};
	logic [1:0] pexp [4] = '{2'h3, 2'h2, 2'h3, 2'h0};
	logic clk_i, rst_n_i, wr_i, rd_i, acquire_i, port_pin_i;
	logic sort_busy_o, result_valid_o, bat_div_en_o;
	logic shared_interrupt_pin_n_o, port_pin_o, port_pin_oe_o;
	logic [3:0] addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic [11:0] result_o;
	logic [2:0] result_chan_o;
	trf_pkg::trf_sample_t sample_i;
	int n_mismatch, n_compared, m;

	trf_top u_trf_top (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .sample_i, .acquire_i, .sort_busy_o, .result_o,
		.result_chan_o, .result_valid_o, .bat_div_en_o,
		.shared_interrupt_pin_n_o, .port_pin_i, .port_pin_o, .port_pin_oe_o);
	trf_host_model u_trf_host_model (.clk_i, .addr_o(addr_i),
		.wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ==========
	// Helpers
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic timed_out;
		n_mismatch++;
		$display("ERROR %0t wait ran out", $time);
		report_and_stop();
	endtask : timed_out

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] v;
		u_trf_host_model.rd_reg(a, v);
		chk(v, e);
	endtask : rd

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		u_trf_host_model.wr_reg(a, d);
	endtask : wr

	// One sample pulse; data lines go to the inverse once released.
	task automatic feed(input logic [11:0] v);
		int k;
		@(posedge clk_i);
		sample_i <= '{1'b1, v};
		@(posedge clk_i);
		sample_i <= '{1'b0, ~v};
		repeat (2) @(posedge clk_i);
		for (k = 0; k < 300 && sort_busy_o !== 1'b0; k++) @(posedge clk_i);
		if (k == 300) timed_out();
	endtask : feed

	task automatic wait_result;
		int k;
		for (k = 0; k < 3000 && result_valid_o !== 1'b1; k++) @(posedge clk_i);
		if (k == 3000) timed_out();
	endtask : wait_result

	initial begin
		repeat (100000) @(posedge clk_i);
		timed_out();
	end

	// ==========
	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		acquire_i = 1'b0;
		port_pin_i = 1'b0;
		sample_i = '0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		foreach (zoff[i]) rd(zoff[i], 16'h0000);
		rd(trf_pkg::OFF_SECOND_CONTROL, trf_pkg::RST_SECOND_CONTROL);
		wr(trf_pkg::OFF_MON_HIGH_LIMIT, 16'h00aa);
		wr(trf_pkg::OFF_MON_LOW_LIMIT, 16'h0078);
		wr(trf_pkg::OFF_MON_RESULT, 16'h0fff);
		rd(trf_pkg::OFF_MON_HIGH_LIMIT, 16'h00aa);
		rd(trf_pkg::OFF_MON_RESULT, 16'h0000);
		foreach (rows[i]) begin
			m = (rows[i].med != 2'h0) ? (2 << rows[i].med) :
				((rows[i].avg == 2'h0) ? 1 : (2 << rows[i].avg));
			wr(trf_pkg::OFF_THIRD_CONTROL, 16'h001f);
			wr(trf_pkg::OFF_SECOND_CONTROL,
				{7'h20, rows[i].avg, rows[i].med, 5'h00});
			wr(trf_pkg::OFF_FIRST_CONTROL, {1'b0, rows[i].chan, 12'h000});
			acquire_i <= 1'b1;
			for (int j = 0; j < m; j++) feed(rows[i].base + 12'((j * 5 % m) * 10));
			chk(16'(bat_div_en_o), 16'(rows[i].chan == 3'h2));
			acquire_i <= 1'b0;
			wait_result();
			chk(16'(result_o), 16'(rows[i].res));
			chk(16'(result_chan_o), 16'(rows[i].chan));
			rd(trf_pkg::OFF_MON_RESULT, 16'(rows[i].res));
			rd(trf_pkg::OFF_THIRD_CONTROL, {11'h000, 3'h7, rows[i].stat});
			chk(16'(shared_interrupt_pin_n_o), 16'(rows[i].stat == 2'h0));
		end
		// Enables off: the status bit still sets, the pin stays quiet.
		wr(trf_pkg::OFF_THIRD_CONTROL, 16'h0013);
		wr(trf_pkg::OFF_SECOND_CONTROL, 16'h4000);
		feed(12'h0ff);
		wait_result();
		rd(trf_pkg::OFF_THIRD_CONTROL, 16'h0011);
		chk(16'(shared_interrupt_pin_n_o), 16'h0001);
		// Port as output in both polarities, then disabled.
		foreach (pcfg[p]) begin
			wr(trf_pkg::OFF_SECOND_CONTROL, pcfg[p]);
			repeat (2) @(posedge clk_i);
			chk(16'({port_pin_oe_o, port_pin_o & port_pin_oe_o}), 16'(pexp[p]));
		end
		// Port as input; host writes to the data bit are dropped.
		port_pin_i <= 1'b1;
		wr(trf_pkg::OFF_SECOND_CONTROL, 16'h2c00);
		repeat (5) @(posedge clk_i);
		rd(trf_pkg::OFF_SECOND_CONTROL, 16'h3c00);
		chk(16'(port_pin_oe_o), 16'h0000);
		wr(trf_pkg::OFF_SECOND_CONTROL, 16'h2800);
		repeat (5) @(posedge clk_i);
		rd(trf_pkg::OFF_SECOND_CONTROL, 16'h2800);
		wr(trf_pkg::OFF_SECOND_CONTROL, 16'h3800);
		rd(trf_pkg::OFF_SECOND_CONTROL, 16'h2800);
		port_pin_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		rd(trf_pkg::OFF_SECOND_CONTROL, 16'h3800);
		report_and_stop();
	end

endmodule : tb_trf_top
